/* verilog/supply_supervisor.sv */
// supply_supervisor: digital core of a multi-supply supervisor with watchdog
// assumes comparator flags and pins are synchronous to i_clk; i_srst models power-up
//
// Summary of operation
// - reset low on undervoltage or manual reset
// - reset stays low 200ms after causes clear
// - overvoltage output low on any overvoltage
// - overvoltage output held 25us after clearing
// - expiry output low when no kick edge
// - either kick edge restarts the watchdog
// - margin low freezes reset output state
// - margin hold outranks manual reset
// - manual reset needs 1us, glitches ignored
// - manual reset reaches output about 300ns after the fall
// - kick levels last at least 50ns
// - idle inputs: controls high, kick low
// - expiry output may drive manual reset
// - initial period 102.4s, normal 1.6s
// - kick edge releases expiry output
`timescale 1ns/1ns
module supply_supervisor #(
  parameter longint unsigned INITIAL_DOG_CYC = supervisor_pkg::INITIAL_DOG_CYC,
  parameter longint unsigned NORMAL_DOG_CYC = supervisor_pkg::NORMAL_DOG_CYC,
  parameter int unsigned RESET_STRETCH_CYC = supervisor_pkg::RESET_STRETCH_CYC
) (
  // clock and power-up reset
  input wire logic i_clk,
  input wire logic i_srst,
  // comparator flags per supply
  input wire logic [supervisor_pkg::SUPPLY_COUNT-1:0] i_under,
  input wire logic [supervisor_pkg::SUPPLY_COUNT-1:0] i_over,
  // flags valid after the power-up delay
  input wire logic i_flags_valid,
  // pins
  supervisor_if.device pins
);
  // filter state for manual reset
  logic [3:0] manual_cnt;
  logic manual_active;
  // reset stretch state
  logic [supervisor_pkg::STRETCH_CNT_W-1:0] rst_cnt;
  logic rst_asserted;
  // overvoltage stretch state
  logic [supervisor_pkg::STRETCH_CNT_W-1:0] high_cnt;
  logic high_asserted;
  // watchdog state
  logic [supervisor_pkg::DOG_CNT_W-1:0] dog_cnt;
  logic kick_prev;
  logic kick_edge;
  logic dog_normal;
  logic dog_expired;
  // combined reset cause
  logic rst_cause;

  // manual reset glitch filter: low must persist to be recognised
  // a single low sample (about 100ns) never reaches the reset path
  // the host holds the pin low for at least 1us, well past the filter
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      manual_cnt <= 4'h0;
      manual_active <= 1'b0;
    end
    else if (pins.manual_rst_n)
    begin
      // high releases at once
      manual_cnt <= 4'h0;
      manual_active <= 1'b0;
    end
    else if (manual_cnt == 4'(supervisor_pkg::MANUAL_FILTER_CYC - 1))
    begin
      // held long enough: recognised, about 200ns after the fall
      manual_active <= 1'b1;
    end
    else
    begin
      manual_cnt <= manual_cnt + 4'h1;
    end
  end

  // reset cause: flags invalid, undervoltage or manual reset
  assign rst_cause = !i_flags_valid || (|i_under) || manual_active;

  // reset output with release stretch and margin freeze
  // margin is tested right after power-up reset so neither manual reset nor expiry can move the output
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rst_asserted <= 1'b1;
      rst_cnt <= '0;
    end
    else if (!pins.margin_n)
    begin
      // margin holds state, overriding manual reset too
      rst_asserted <= rst_asserted;
    end
    else if (rst_cause)
    begin
      rst_asserted <= 1'b1;
      rst_cnt <= '0;
    end
    else if (rst_asserted)
    begin
      // count out the stretch after all causes clear
      if (rst_cnt == supervisor_pkg::STRETCH_CNT_W'(RESET_STRETCH_CYC - 1))
      begin
        rst_asserted <= 1'b0;
        rst_cnt <= '0;
      end
      else
      begin
        rst_cnt <= rst_cnt + 1'b1;
      end
    end
  end

  // overvoltage output with release stretch
  // over flags count only once the comparators report valid levels
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      high_asserted <= 1'b0;
      high_cnt <= '0;
    end
    else if (i_flags_valid && (|i_over))
    begin
      high_asserted <= 1'b1;
      high_cnt <= '0;
    end
    else if (high_asserted)
    begin
      // hold for the stretch after clearing
      if (high_cnt == supervisor_pkg::STRETCH_CNT_W'(supervisor_pkg::HIGH_STRETCH_CYC - 1))
      begin
        high_asserted <= 1'b0;
        high_cnt <= '0;
      end
      else
      begin
        high_cnt <= high_cnt + 1'b1;
      end
    end
  end

  // kick edge detection, either polarity
  // the previous level resets to the idle low level, so no false edge follows reset
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      kick_prev <= 1'b0; // idle kick reads low
    end
    else
    begin
      kick_prev <= pins.dog_kick;
    end
  end
  assign kick_edge = pins.dog_kick ^ kick_prev;

  // watchdog timer: initial period until the first kick, then normal
  // the counter stops once expired, so the flag stands until a kick or a reset
  // expiry never asserts reset here; the board loops it into manual reset
  always_ff @(posedge i_clk)
  begin
    if (i_srst || rst_asserted)
    begin
      // restart with the initial period after reset release
      dog_cnt <= '0;
      dog_normal <= 1'b0;
      dog_expired <= 1'b0;
    end
    else if (kick_edge)
    begin
      // a kick restarts the period and releases expiry
      dog_cnt <= '0;
      dog_normal <= 1'b1;
      dog_expired <= 1'b0;
    end
    else if (!dog_expired)
    begin
      if (dog_normal
          ? dog_cnt == supervisor_pkg::DOG_CNT_W'(NORMAL_DOG_CYC - 1)
          : dog_cnt == supervisor_pkg::DOG_CNT_W'(INITIAL_DOG_CYC - 1))
      begin
        dog_expired <= 1'b1;
        dog_cnt <= '0;
      end
      else
      begin
        dog_cnt <= dog_cnt + 1'b1;
      end
    end
  end

  // open-drain pins: drive low (enable low) while asserted
  // the levels are constant low and only the enables move, as on a real open drain
  // all enables come straight from registers, so the pins never glitch
  assign pins.rst_out = 1'b0;
  assign pins.rst_oe_n = !rst_asserted;
  assign pins.high_fault_out = 1'b0;
  assign pins.high_fault_oe_n = !high_asserted;
  assign pins.dog_expired_out = 1'b0;
  assign pins.dog_expired_oe_n = !dog_expired;
endmodule

/* verilog/supervisor_pkg.sv */
// supervisor_pkg: shared constants for the supply supervisor and its host end
// assumes a 10 MHz system clock on both ends
package supervisor_pkg;
  // clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 100;
  // number of monitored supply inputs
  localparam int unsigned SUPPLY_COUNT = 6;
  // reset release stretch, in ms
  localparam int unsigned RESET_STRETCH_MS = 200;
  localparam int unsigned RESET_STRETCH_CYC = RESET_STRETCH_MS * 1000000 / CLK_PERIOD_NS;
  // overvoltage release stretch, in us
  localparam int unsigned HIGH_STRETCH_US = 25;
  localparam int unsigned HIGH_STRETCH_CYC = HIGH_STRETCH_US * 1000 / CLK_PERIOD_NS;
  // manual reset glitch filter, in ns (about 100 ns rejected)
  localparam int unsigned MANUAL_FILTER_NS = 100;
  localparam int unsigned MANUAL_FILTER_CYC =
    (MANUAL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // least manual reset pulse the host gives, in ns
  localparam int unsigned MANUAL_PULSE_NS = 1000;
  localparam int unsigned MANUAL_PULSE_CYC =
    (MANUAL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least level time of a kick, in ns
  localparam int unsigned KICK_LEVEL_NS = 50;
  localparam int unsigned KICK_LEVEL_CYC =
    (KICK_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // initial and normal watchdog periods, in ms (102.4 s and 1.6 s)
  localparam longint unsigned INITIAL_DOG_MS = 102400;
  localparam longint unsigned NORMAL_DOG_MS = 1600;
  localparam longint unsigned INITIAL_DOG_CYC = INITIAL_DOG_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint unsigned NORMAL_DOG_CYC = NORMAL_DOG_MS * 1000000 / CLK_PERIOD_NS;
  // counter widths
  localparam int unsigned DOG_CNT_W = 31;
  localparam int unsigned STRETCH_CNT_W = 21;
  // host kick interval default, in ms, inside the normal period
  localparam longint unsigned HOST_KICK_MS = 800;
  localparam longint unsigned HOST_KICK_CYC = HOST_KICK_MS * 1000000 / CLK_PERIOD_NS;
endpackage

/* verilog/supervisor_if.sv */
// supervisor_if: pins between the supervisor and the host processor
// open-drain outputs carry a level and an enable; enable low means pulled low
`timescale 1ns/1ns
interface supervisor_if;
  // reset output, open drain
  logic rst_out;
  logic rst_oe_n;
  // overvoltage output, open drain
  logic high_fault_out;
  logic high_fault_oe_n;
  // watchdog expiry output, open drain
  logic dog_expired_out;
  logic dog_expired_oe_n;
  // host-driven inputs
  logic manual_rst_n;
  logic margin_n;
  logic dog_kick;
  // resolved levels, pulled up when released
  logic rst_n;
  logic high_fault_n;
  logic dog_expired_n;
  assign rst_n = rst_oe_n ? 1'b1 : rst_out;
  assign high_fault_n = high_fault_oe_n ? 1'b1 : high_fault_out;
  assign dog_expired_n = dog_expired_oe_n ? 1'b1 : dog_expired_out;
  modport device (
    output rst_out, rst_oe_n, high_fault_out, high_fault_oe_n,
    output dog_expired_out, dog_expired_oe_n,
    input manual_rst_n, margin_n, dog_kick
  );
  modport host (
    input rst_n, high_fault_n, dog_expired_n,
    output manual_rst_n, margin_n, dog_kick
  );
endinterface

/* verilog/supervisor_host.sv */
// supervisor_host: host end that kicks the watchdog and drives control pins
// assumes the supervisor pins are synchronous to i_clk
`timescale 1ns/1ns
module supervisor_host #(
  parameter longint unsigned HOST_KICK_CYC = supervisor_pkg::HOST_KICK_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // user controls
  input wire logic i_kick_enable,
  input wire logic i_margin_req,
  input wire logic i_manual_req,
  // observed supervisor state
  output logic o_in_reset,
  output logic o_high_fault,
  output logic o_dog_expired,
  // pins
  supervisor_if.host pins
);
  // kick interval counter
  logic [supervisor_pkg::DOG_CNT_W-1:0] kick_cnt;
  // kick pin level
  logic kick_level;
  // manual reset stretch, keeps the pulse at least 1us
  logic [3:0] manual_cnt;
  logic manual_low;

  // toggle the kick well inside each period; each level lasts many cycles
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      kick_cnt <= '0;
      kick_level <= 1'b0;
    end
    else if (!i_kick_enable || !pins.rst_n)
    begin
      kick_cnt <= '0;
    end
    else if (kick_cnt == supervisor_pkg::DOG_CNT_W'(HOST_KICK_CYC - 1))
    begin
      kick_cnt <= '0;
      kick_level <= !kick_level;
    end
    else
    begin
      kick_cnt <= kick_cnt + 1'b1;
    end
  end

  // manual reset: requests and watchdog expiry both pull it low
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      manual_cnt <= 4'h0;
      manual_low <= 1'b0;
    end
    else if (i_manual_req || !pins.dog_expired_n)
    begin
      manual_cnt <= 4'(supervisor_pkg::MANUAL_PULSE_CYC);
      manual_low <= 1'b1;
    end
    else if (manual_cnt != 4'h0)
    begin
      manual_cnt <= manual_cnt - 4'h1;
    end
    else
    begin
      manual_low <= 1'b0;
    end
  end

  // observed levels
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_in_reset <= 1'b1;
      o_high_fault <= 1'b0;
      o_dog_expired <= 1'b0;
    end
    else
    begin
      o_in_reset <= !pins.rst_n;
      o_high_fault <= !pins.high_fault_n;
      o_dog_expired <= !pins.dog_expired_n;
    end
  end

  // pin drive
  assign pins.dog_kick = kick_level;
  assign pins.manual_rst_n = !manual_low;
  assign pins.margin_n = !i_margin_req;
endmodule

/* tb/supervisor_properties.sv */
// supervisor_properties: timing checks on the pins between supervisor and host
// assumes one clock domain, a sync reset and pins already resolved by the interface
`timescale 1ns/1ns
module supervisor_properties #(
  parameter longint unsigned INITIAL_DOG_CYC = 200,
  parameter longint unsigned NORMAL_DOG_CYC = 50,
  parameter int unsigned RESET_STRETCH_CYC = 20
) (
  // clock, reset and comparator flags
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [supervisor_pkg::SUPPLY_COUNT-1:0] i_under,
  input wire logic [supervisor_pkg::SUPPLY_COUNT-1:0] i_over,
  input wire logic i_flags_valid,
  // resolved pins
  input wire logic rst_n,
  input wire logic high_fault_n,
  input wire logic dog_expired_n,
  input wire logic manual_rst_n,
  input wire logic margin_n,
  input wire logic dog_kick
);
  localparam int unsigned HIGH_HOLD = supervisor_pkg::HIGH_STRETCH_CYC; // overvoltage stretch
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  logic [9:0] quiet_cnt; // cycles free of margin and of any reset cause
  logic [9:0] hq_cnt; // cycles free of overvoltage
  logic [31:0] since; // cycles since release or last kick
  logic [31:0] limit; // watchdog period now in force
  logic kick_q; // kick level one edge ago
  logic kicked; // normal period once kicked
  assign limit = kicked ? 32'(NORMAL_DOG_CYC) : 32'(INITIAL_DOG_CYC);
  // quiet cycles, saturating
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !manual_rst_n || !margin_n || !i_flags_valid || (|i_under))
      quiet_cnt <= '0;
    else if (quiet_cnt != 10'h3ff)
      quiet_cnt <= quiet_cnt + 10'h001;
  end
  // overvoltage-free cycles, saturating
  always_ff @(posedge i_clk)
  begin
    if (i_srst || ((|i_over) && i_flags_valid))
      hq_cnt <= '0;
    else if (hq_cnt != 10'h3ff)
      hq_cnt <= hq_cnt + 10'h001;
  end
  // watchdog age, cleared by reset or a kick edge
  always_ff @(posedge i_clk)
  begin
    kick_q <= dog_kick;
    if (i_srst || !rst_n)
    begin
      since <= '0;
      kicked <= 1'b0;
    end
    else if (dog_kick != kick_q)
    begin
      since <= '0;
      kicked <= 1'b1;
    end
    else
      since <= since + 32'h1;
  end
  under_resets_a: assert property (
    margin_n && ((|i_under) || !i_flags_valid) |=> !rst_n)
    else $error("reset missing on undervoltage");
  manual_resets_a: assert property (
    (!manual_rst_n && margin_n) [*2] ##1 margin_n |=> !rst_n)
    else $error("reset missing on manual reset");
  stretch_min_a: assert property (
    $rose(rst_n) |-> quiet_cnt >= RESET_STRETCH_CYC)
    else $error("reset released early");
  high_fault_a: assert property (
    (|i_over) && i_flags_valid |=> !high_fault_n)
    else $error("overvoltage flag missing");
  high_hold_a: assert property (
    $rose(high_fault_n) |-> hq_cnt >= HIGH_HOLD)
    else $error("overvoltage flag released early");
  margin_freeze_a: assert property (
    !$past(margin_n) |-> $stable(rst_n))
    else $error("reset moved while frozen");
  kick_clear_a: assert property (
    $changed(dog_kick) && !dog_expired_n |=> dog_expired_n)
    else $error("expiry not cleared by kick");
  dog_time_a: assert property (
    $fell(dog_expired_n) |-> since + 32'h3 >= limit && since <= limit + 32'h1)
    else $error("expiry at wrong time");
  cover property ($fell(high_fault_n));
  cover property ($fell(dog_expired_n));
  cover property (!margin_n && (|i_under));
endmodule

/* tb/supply_supervisor_reset_watchdog_tb.sv */
// supply_supervisor_reset_watchdog_tb: supervisor and host joined, flags and controls driven
// assumes 10 MHz clock and shortened watchdog and reset stretch counts
`timescale 1ns/1ns
module supply_supervisor_reset_watchdog_tb;
  typedef struct packed {
    logic [5:0] un;
    logic [5:0] ov;
    logic [2:0] vmg; // valid, manual, margin
    logic [1:0] e; // in reset, high fault
  } row_t;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [5:0] i_under = 6'h00;
  logic [5:0] i_over = 6'h00;
  logic i_flags_valid = 1'b1;
  logic i_kick_enable = 1'b1;
  logic i_margin_req = 1'b0;
  logic i_manual_req = 1'b0;
  logic o_in_reset;
  logic o_high_fault;
  logic o_dog_expired;
  logic [2:0] obs; // observed flags by index
  int fail_count = 0;
  int comparisons = 0;
  int n;
  row_t rows [8];
  // shortened counts; the checker's defaults hold the same values
  localparam longint unsigned DOG_INIT = 200;
  localparam longint unsigned DOG_NORM = 50;
  localparam int unsigned STRETCH = 20;
  localparam longint unsigned KICK_CYC = 20;
  assign obs = {o_dog_expired, o_high_fault, o_in_reset};
  supervisor_if pins();
  supply_supervisor #(.INITIAL_DOG_CYC(DOG_INIT), .NORMAL_DOG_CYC(DOG_NORM),
    .RESET_STRETCH_CYC(STRETCH))
  supply_supervisor_inst (.i_clk(i_clk), .i_srst(i_srst), .i_under(i_under),
    .i_over(i_over), .i_flags_valid(i_flags_valid), .pins(pins));
  supervisor_host #(.HOST_KICK_CYC(KICK_CYC)) supervisor_host_inst (.i_clk(i_clk),
    .i_srst(i_srst), .i_kick_enable(i_kick_enable), .i_margin_req(i_margin_req),
    .i_manual_req(i_manual_req), .o_in_reset(o_in_reset), .o_high_fault(o_high_fault),
    .o_dog_expired(o_dog_expired), .pins(pins));
  supervisor_properties supervisor_properties_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_under(i_under),
    .i_over(i_over), .i_flags_valid(i_flags_valid), .rst_n(pins.rst_n),
    .high_fault_n(pins.high_fault_n), .dog_expired_n(pins.dog_expired_n),
    .manual_rst_n(pins.manual_rst_n), .margin_n(pins.margin_n), .dog_kick(pins.dog_kick));
  // 100 ns clock
  initial forever #50 i_clk = ~i_clk;
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // cycles until flag s reaches v, bounded
  task meas(input int s, input logic v, output int cnt);
    cnt = 0;
    while (obs[s] !== v && cnt < 1000)
    begin
      @(negedge i_clk);
      cnt++;
    end
  endtask
  // verdict and end of run
  task finish_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, about three times the expected run
  initial
  begin
    #1000000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    rows = '{'{6'h00, 6'h00, 3'h4, 2'h0}, '{6'h01, 6'h00, 3'h5, 2'h0},
      '{6'h00, 6'h00, 3'h7, 2'h0}, '{6'h20, 6'h00, 3'h4, 2'h2},
      '{6'h00, 6'h08, 3'h4, 2'h1}, '{6'h04, 6'h01, 3'h4, 2'h3},
      '{6'h00, 6'h00, 3'h6, 2'h2}, '{6'h00, 6'h3f, 3'h0, 2'h2}};
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    // level cases: margin first so it is in force before the flags
    foreach (rows[i])
    begin
      @(negedge i_clk);
      i_margin_req = rows[i].vmg[0];
      repeat (3) @(negedge i_clk);
      {i_flags_valid, i_manual_req} = rows[i].vmg[2:1];
      i_under = rows[i].un;
      i_over = rows[i].ov;
      repeat (300) @(negedge i_clk);
      check({30'h0, o_in_reset, o_high_fault}, {30'h0, rows[i].e});
    end
    // reset release stretch
    {i_flags_valid, i_over} = {1'b1, 6'h00};
    meas(0, 1'b0, n);
    i_under = 6'h02;
    repeat (5) @(negedge i_clk);
    i_under = 6'h00;
    meas(0, 1'b0, n);
    check(32'(n inside {[STRETCH:STRETCH + 4]}), 32'h1);
    // overvoltage release stretch
    i_over = 6'h10;
    repeat (5) @(negedge i_clk);
    i_over = 6'h00;
    meas(1, 1'b0, n);
    check(32'(n inside {[supervisor_pkg::HIGH_STRETCH_CYC:supervisor_pkg::HIGH_STRETCH_CYC + 4]}),
      32'h1);
    // watchdog starved in normal mode, expiry then reset via manual path
    i_kick_enable = 1'b0;
    meas(2, 1'b1, n);
    check(32'(n < 80), 32'h1);
    meas(0, 1'b1, n);
    check(32'(n < 10), 32'h1);
    meas(0, 1'b0, n);
    repeat (150) @(negedge i_clk);
    check({31'h0, o_dog_expired}, 32'h0);
    meas(2, 1'b1, n);
    check(32'(n < 100), 32'h1);
    // expiry resets again; then margin holds so the next expiry cannot reset
    meas(0, 1'b1, n);
    check(32'(n < 10), 32'h1);
    meas(0, 1'b0, n);
    i_margin_req = 1'b1;
    meas(2, 1'b1, n);
    check(32'(n inside {[DOG_INIT:DOG_INIT + 4]}), 32'h1);
    repeat (10) @(negedge i_clk);
    check({31'h0, o_in_reset}, 32'h0);
    // kicks resume and release the expiry with no reset in between
    i_kick_enable = 1'b1;
    meas(2, 1'b0, n);
    check(32'(n inside {[KICK_CYC:KICK_CYC + 4]}), 32'h1);
    finish_test();
  end
endmodule
